// ==== common/expander_pkg.sv ====
// Shared constants, register map and address decoding for the I/O expander.
`default_nettype none

package expander_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [PORT_W-1:0] DIR_RST = 8'hFF;
    localparam logic [PORT_W-1:0] ZERO_RST = 8'h00;

    // ------------------------------------------------------------------
    // Register index within one port's group
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_DIR = 4'h0;
    localparam logic [3:0] IDX_POL = 4'h1;
    localparam logic [3:0] IDX_IRQ_EN = 4'h2;
    localparam logic [3:0] IDX_DEFAULT_COMPARE_VALUE = 4'h3;
    localparam logic [3:0] IDX_CSEL = 4'h4;
    localparam logic [3:0] IDX_CFG = 4'h5;
    localparam logic [3:0] IDX_PULLUP = 4'h6;
    localparam logic [3:0] IDX_FLAGS = 4'h7;
    localparam logic [3:0] IDX_CAPTURE = 4'h8;
    localparam logic [3:0] IDX_PORT = 4'h9;
    localparam logic [3:0] IDX_LATCH = 4'hA;

    // Split map: address bits 7:5 must equal this; paired map ends here.
    localparam logic [2:0] SPLIT_HIGH_ZERO = 3'h0;
    localparam logic [ADDR_W-1:0] PAIRED_LAST = 8'h15;

    // ------------------------------------------------------------------
    // Configuration register fields
    // ------------------------------------------------------------------
    localparam int CFG_BANK = 7;
    localparam int CFG_MIRROR = 6;
    localparam int CFG_HOLD = 5;
    localparam int CFG_OD = 2;
    localparam int CFG_POL = 1;
    localparam int CFG_CLRSEL = 0;
    localparam logic [PORT_W-1:0] CFG_WMASK = 8'hE7;

    typedef struct packed {
        logic hit;
        logic port_b;
        logic [3:0] idx;
    } decode_t;

    // Maps a byte address to port and register index for either layout.
    function automatic decode_t decode_addr(input logic [ADDR_W-1:0] a,
                                            input logic split);
        decode_t r;
        r = '{hit: 1'b0, port_b: 1'b0, idx: IDX_DIR};
        if (split)
        begin
            r.hit = (a[7:5] == SPLIT_HIGH_ZERO) && (a[3:0] <= IDX_LATCH);
            r.port_b = a[4];
            r.idx = a[3:0];
        end
        else
        begin
            r.hit = (a <= PAIRED_LAST);
            r.port_b = a[0];
            r.idx = a[4:1];
        end
        return r;
    endfunction

endpackage

`default_nettype wire

// ==== src/port_irq_unit.sv ====
// Change detection, flags, capture and pending interrupt for one port.
`default_nettype none

module port_irq_unit #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Synchronised pin levels and configuration
    input wire logic [WIDTH-1:0] pins_i,
    input wire logic [WIDTH-1:0] dir_in_i,
    input wire logic [WIDTH-1:0] irq_en_i,
    input wire logic [WIDTH-1:0] default_compare_value_i,
    input wire logic [WIDTH-1:0] csel_i,
    // Clearing read of this port
    input wire logic clear_i,
    // State
    output logic [WIDTH-1:0] flags_o,
    output logic [WIDTH-1:0] capture_o,
    output logic pending_o
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("port_irq_unit: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] ref_q, ref_d;
    logic [WIDTH-1:0] flags_q, flags_d;
    logic [WIDTH-1:0] cap_q, cap_d;
    logic pend_q, pend_d;
    logic [WIDTH-1:0] mismatch;

    always_comb
    begin
        // Only enabled input pins take part; outputs never do.
        mismatch = irq_en_i & dir_in_i
                 & ((csel_i & (pins_i ^ default_compare_value_i))
                 | (~csel_i & (pins_i ^ ref_q)));
        // The reference follows the pins until an interrupt freezes it.
        ref_d = pend_q ? ref_q : pins_i;
        flags_d = flags_q;
        cap_d = cap_q;
        pend_d = pend_q;
        if (!pend_q && (mismatch != '0))
        begin
            pend_d = 1'b1;
            flags_d = mismatch;
            cap_d = pins_i;
        end
        else if (pend_q && clear_i && (mismatch == '0))
        begin
            // A live condition keeps the interrupt, so the set wins here.
            pend_d = 1'b0;
            flags_d = '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ref_q <= '0;
            flags_q <= '0;
            cap_q <= '0;
            pend_q <= 1'b0;
        end
        else
        begin
            ref_q <= ref_d;
            flags_q <= flags_d;
            cap_q <= cap_d;
            pend_q <= pend_d;
        end
    end

    assign flags_o = flags_q;
    assign capture_o = cap_q;
    assign pending_o = pend_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_set_on_mismatch;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!pend_q && mismatch != '0) |=>
            (pend_q && flags_q == $past(mismatch) && cap_q == $past(pins_i));
    endproperty
    a_set_on_mismatch: assert property (p_set_on_mismatch)
        else $error("interrupt not raised with flags and capture");

    property p_clear_blocked;
        @(posedge ref_clk_i) disable iff (rst_i)
        (pend_q && clear_i && mismatch != '0) |=> pend_q;
    endproperty
    a_clear_blocked: assert property (p_clear_blocked)
        else $error("interrupt cleared while condition active");

    property p_capture_held;
        @(posedge ref_clk_i) disable iff (rst_i)
        (pend_q && !clear_i) |=> (pend_q && $stable(cap_q));
    endproperty
    a_capture_held: assert property (p_capture_held)
        else $error("capture changed while interrupt pending");

endmodule

`default_nettype wire

// ==== src/io_expander_change_irq_config.sv ====
// Register file, address pointer and interrupt outputs of the I/O expander.
//
// Contract
// - Default-compare pin differing from its compare bit raises an interrupt.
// - Source bit 1 compares with default value, 0 with previous value.
// - Paired map: A then B per register, spanning 00h-15h.
// - Map change acts on the next byte; pointer keeps its value.
// - Merge bit 1 drives both lines from either port; else per port.
// - Hold bit 1 freezes the pointer; 0 increments after each byte.
// - Open-drain bit 1 makes lines open-drain, ignoring polarity.
// - Driven lines: polarity 1 active-high, 0 active-low.
// - Clear select 1: capture read clears; 0: port read clears.
// - A clearing read works only once the condition is gone.
// - Configuration bits 4 and 3 always read zero.
// - Pull-up bit 1 enables the pin's pull-up, input or output.
// - Flag bit reads 1 for the enabled pin that caused the interrupt.
// - Flag register is read-only and ignores writes.
// - Capture loads pin levels only when an interrupt occurs.
// - Capture holds until the interrupt is cleared by a clearing read.
// - Port read returns pin levels XOR polarity bits; port write updates the latch.
// - Enable bit 1 lets its pin take part in change detection.
// - Only enabled input pins can interrupt; outputs never do.
`default_nettype none

module io_expander_change_irq_config
    import expander_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Byte access from the serial engine
    input wire logic addr_load_i,
    input wire logic [expander_pkg::ADDR_W-1:0] addr_i,
    input wire logic wr_strobe_i,
    input wire logic [expander_pkg::PORT_W-1:0] wr_data_i,
    input wire logic rd_strobe_i,
    output logic [expander_pkg::PORT_W-1:0] rd_data_o,
    // Port pins
    input wire logic [expander_pkg::PORT_W-1:0] pins_a_i,
    input wire logic [expander_pkg::PORT_W-1:0] pins_b_i,
    output logic [expander_pkg::PORT_W-1:0] latch_a_o,
    output logic [expander_pkg::PORT_W-1:0] latch_b_o,
    output logic [expander_pkg::PORT_W-1:0] dir_in_a_o,
    output logic [expander_pkg::PORT_W-1:0] dir_in_b_o,
    output logic [expander_pkg::PORT_W-1:0] pullup_a_o,
    output logic [expander_pkg::PORT_W-1:0] pullup_b_o,
    // Interrupt pads
    output logic irq_line_a_o,
    output logic irq_line_a_oe_o,
    output logic irq_line_b_o,
    output logic irq_line_b_oe_o
);

    import expander_pkg::*;

    typedef logic [PORT_W-1:0] byte_t;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    byte_t meta_q [2];
    byte_t pins_s_q [2];

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q[0] <= ZERO_RST;
            meta_q[1] <= ZERO_RST;
            pins_s_q[0] <= ZERO_RST;
            pins_s_q[1] <= ZERO_RST;
        end
        else
        begin
            meta_q[0] <= pins_a_i;
            meta_q[1] <= pins_b_i;
            pins_s_q[0] <= meta_q[0];
            pins_s_q[1] <= meta_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    byte_t dir_q [2], dir_d [2];
    byte_t pol_q [2], pol_d [2];
    byte_t en_q [2], en_d [2];
    byte_t defv_q [2], defv_d [2];
    byte_t csel_q [2], csel_d [2];
    byte_t pu_q [2], pu_d [2];
    byte_t latch_q [2], latch_d [2];
    byte_t cfg_q, cfg_d;
    byte_t rd_q, rd_d;
    logic [ADDR_W-1:0] ptr_q, ptr_d;
    logic [1:0] clear;
    byte_t flags [2];
    byte_t capture [2];
    logic [1:0] pending;
    decode_t dec;
    logic port;
    logic byte_done;

    always_comb
    begin
        dir_d = dir_q;
        pol_d = pol_q;
        en_d = en_q;
        defv_d = defv_q;
        csel_d = csel_q;
        pu_d = pu_q;
        latch_d = latch_q;
        cfg_d = cfg_q;
        rd_d = rd_q;
        ptr_d = ptr_q;
        clear = 2'b00;
        // Decode always uses the map bit as it stands now, so a map change
        // applies from the byte after the one that wrote it.
        dec = decode_addr(ptr_q, cfg_q[CFG_BANK]);
        port = dec.port_b;
        // A pointer load in the same cycle as a strobe wins; the strobe is lost.
        byte_done = !addr_load_i && (wr_strobe_i || rd_strobe_i);
        if (addr_load_i)
        begin
            ptr_d = addr_i;
        end
        else if (byte_done && !cfg_q[CFG_HOLD])
        begin
            ptr_d = ptr_q + 8'h01;
        end
        if (byte_done && wr_strobe_i && dec.hit)
        begin
            unique case (dec.idx)
                IDX_DIR: dir_d[port] = wr_data_i;
                IDX_POL: pol_d[port] = wr_data_i;
                IDX_IRQ_EN: en_d[port] = wr_data_i;
                IDX_DEFAULT_COMPARE_VALUE: defv_d[port] = wr_data_i;
                IDX_CSEL: csel_d[port] = wr_data_i;
                IDX_CFG: cfg_d = wr_data_i & CFG_WMASK;
                IDX_PULLUP: pu_d[port] = wr_data_i;
                IDX_PORT: latch_d[port] = wr_data_i;
                IDX_LATCH: latch_d[port] = wr_data_i;
                // Flags and capture are read-only.
                default: ;
            endcase
        end
        else if (byte_done && rd_strobe_i)
        begin
            rd_d = ZERO_RST;
            if (dec.hit)
            begin
                unique case (dec.idx)
                    IDX_DIR: rd_d = dir_q[port];
                    IDX_POL: rd_d = pol_q[port];
                    IDX_IRQ_EN: rd_d = en_q[port];
                    IDX_DEFAULT_COMPARE_VALUE: rd_d = defv_q[port];
                    IDX_CSEL: rd_d = csel_q[port];
                    IDX_CFG: rd_d = cfg_q;
                    IDX_PULLUP: rd_d = pu_q[port];
                    IDX_FLAGS: rd_d = flags[port];
                    IDX_CAPTURE: rd_d = capture[port];
                    IDX_PORT: rd_d = pins_s_q[port] ^ pol_q[port];
                    IDX_LATCH: rd_d = latch_q[port];
                    default: rd_d = ZERO_RST;
                endcase
                // Only the selected register's read counts as clearing.
                if ((dec.idx == IDX_CAPTURE && cfg_q[CFG_CLRSEL])
                    || (dec.idx == IDX_PORT && !cfg_q[CFG_CLRSEL]))
                begin
                    clear[port] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int p = 0; p < 2; p++)
            begin
                dir_q[p] <= DIR_RST;
                pol_q[p] <= ZERO_RST;
                en_q[p] <= ZERO_RST;
                defv_q[p] <= ZERO_RST;
                csel_q[p] <= ZERO_RST;
                pu_q[p] <= ZERO_RST;
                latch_q[p] <= ZERO_RST;
            end
            cfg_q <= ZERO_RST;
            rd_q <= ZERO_RST;
            ptr_q <= '0;
        end
        else
        begin
            dir_q <= dir_d;
            pol_q <= pol_d;
            en_q <= en_d;
            defv_q <= defv_d;
            csel_q <= csel_d;
            pu_q <= pu_d;
            latch_q <= latch_d;
            cfg_q <= cfg_d;
            rd_q <= rd_d;
            ptr_q <= ptr_d;
        end
    end

    // ------------------------------------------------------------------
    // Per-port change detection
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++)
    begin : g_port
        port_irq_unit #(
            .WIDTH(PORT_W)
        ) u_irq (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .pins_i(pins_s_q[g]),
            .dir_in_i(dir_q[g]),
            .irq_en_i(en_q[g]),
            .default_compare_value_i(defv_q[g]),
            .csel_i(csel_q[g]),
            .clear_i(clear[g]),
            .flags_o(flags[g]),
            .capture_o(capture[g]),
            .pending_o(pending[g])
        );
    end

    // ------------------------------------------------------------------
    // Interrupt pads
    // ------------------------------------------------------------------
    logic act_a, act_b;

    always_comb
    begin
        // Merging only routes the lines; each port still clears on its own.
        act_a = cfg_q[CFG_MIRROR] ? |pending : pending[0];
        act_b = cfg_q[CFG_MIRROR] ? |pending : pending[1];
        if (cfg_q[CFG_OD])
        begin
            // Open-drain pulls low when active and floats otherwise.
            irq_line_a_o = 1'b0;
            irq_line_a_oe_o = act_a;
            irq_line_b_o = 1'b0;
            irq_line_b_oe_o = act_b;
        end
        else
        begin
            irq_line_a_o = ~(act_a ^ cfg_q[CFG_POL]);
            irq_line_a_oe_o = 1'b1;
            irq_line_b_o = ~(act_b ^ cfg_q[CFG_POL]);
            irq_line_b_oe_o = 1'b1;
        end
    end

    assign rd_data_o = rd_q;
    assign latch_a_o = latch_q[0];
    assign latch_b_o = latch_q[1];
    assign dir_in_a_o = dir_q[0];
    assign dir_in_b_o = dir_q[1];
    assign pullup_a_o = pu_q[0];
    assign pullup_b_o = pu_q[1];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_ptr_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (byte_done && cfg_q[CFG_HOLD]) |=> $stable(ptr_q);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold)
        else $error("pointer moved while hold bit set");

    property p_ptr_inc;
        @(posedge ref_clk_i) disable iff (rst_i)
        (byte_done && !cfg_q[CFG_HOLD]) |=> (ptr_q == $past(ptr_q) + 8'h01);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc)
        else $error("pointer did not increment after byte");

    property p_cfg_unimpl;
        @(posedge ref_clk_i) disable iff (rst_i)
        cfg_q[4:3] == 2'b00;
    endproperty
    a_cfg_unimpl: assert property (p_cfg_unimpl)
        else $error("unimplemented configuration bits set");

    property p_mirror;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_q[CFG_MIRROR] && !cfg_q[CFG_OD]) |->
            (irq_line_a_o == irq_line_b_o
             && ((irq_line_a_o == cfg_q[CFG_POL]) == (pending != 2'b00)));
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("merged interrupt lines disagree");

    property p_od;
        @(posedge ref_clk_i) disable iff (rst_i)
        cfg_q[CFG_OD] |-> (!irq_line_a_o && irq_line_a_oe_o == act_a);
    endproperty
    a_od: assert property (p_od)
        else $error("open-drain line driven wrongly");

    property p_pol;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg_q[CFG_OD] && act_b) |-> (irq_line_b_o == cfg_q[CFG_POL]);
    endproperty
    a_pol: assert property (p_pol)
        else $error("driven line has wrong active level");

    property p_flags_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        (byte_done && wr_strobe_i && dec.hit && dec.idx == IDX_FLAGS
            && !dec.port_b && pending[0]) |=> $stable(flags[0]);
    endproperty
    a_flags_write: assert property (p_flags_write)
        else $error("flag register altered by a write");

endmodule

`default_nettype wire

// ==== testbench/expander_host_model.sv ====
// Byte-level host model that stands in for the serial engine's master side.
`default_nettype none

module expander_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Byte access towards the expander
    output logic addr_load_o,
    output logic [expander_pkg::ADDR_W-1:0] addr_o,
    output logic wr_strobe_o,
    output logic [expander_pkg::PORT_W-1:0] wr_data_o,
    output logic rd_strobe_o,
    input wire logic [expander_pkg::PORT_W-1:0] rd_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import expander_pkg::*;

    // ----------------------------------------------------------------
    // Byte transfers
    // ----------------------------------------------------------------
    initial
    begin
        addr_load_o = 1'b0;
        addr_o = 8'h00;
        wr_strobe_o = 1'b0;
        wr_data_o = 8'h00;
        rd_strobe_o = 1'b0;
    end

    // Lines not qualified by a strobe carry the inverse of the last value,
    // so a design that samples them late sees a wrong value.
    task automatic set_addr(input logic [ADDR_W-1:0] a);
        @(posedge ref_clk_i);
        addr_load_o <= 1'b1;
        addr_o <= a;
        @(posedge ref_clk_i);
        addr_load_o <= 1'b0;
        addr_o <= ~a;
    endtask

    // One byte per call; bank changes are sent as a lone byte.
    task automatic put_byte(input logic [PORT_W-1:0] d);
        @(posedge ref_clk_i);
        wr_strobe_o <= 1'b1;
        wr_data_o <= d;
        @(posedge ref_clk_i);
        wr_strobe_o <= 1'b0;
        wr_data_o <= ~d;
        // The write lands on this edge; let it settle before anyone looks.
        #1;
    endtask

    task automatic get_byte(output logic [PORT_W-1:0] d);
        @(posedge ref_clk_i);
        rd_strobe_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_strobe_o <= 1'b0;
        #1;
        d = rd_data_i;
    endtask
endmodule

`default_nettype wire

// ==== testbench/test_io_expander_change_irq_config.sv ====
// Self-checking bench for the expander's change interrupt and configuration.
`default_nettype none

module test_io_expander_change_irq_config;
    timeunit 1ns;
    timeprecision 1ps;
    import expander_pkg::*;

    logic ref_clk_i;
    logic rst_i;
    logic addr_load, wr_strobe, rd_strobe;
    logic [7:0] addr, wr_data, rd_data, pins_a, pins_b, v;
    logic [7:0] latch_a, latch_b, dir_a, dir_b, pu_a, pu_b;
    logic line_a, line_a_oe, line_b, line_b_oe;
    int n_mismatch = 0;
    int check_count = 0;

    io_expander_change_irq_config i_io_expander_change_irq_config (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_load_i(addr_load),
        .addr_i(addr), .wr_strobe_i(wr_strobe), .wr_data_i(wr_data),
        .rd_strobe_i(rd_strobe), .rd_data_o(rd_data), .pins_a_i(pins_a),
        .pins_b_i(pins_b), .latch_a_o(latch_a), .latch_b_o(latch_b),
        .dir_in_a_o(dir_a), .dir_in_b_o(dir_b), .pullup_a_o(pu_a),
        .pullup_b_o(pu_b), .irq_line_a_o(line_a),
        .irq_line_a_oe_o(line_a_oe), .irq_line_b_o(line_b),
        .irq_line_b_oe_o(line_b_oe));

    expander_host_model i_expander_host_model (
        .ref_clk_i(ref_clk_i), .addr_load_o(addr_load), .addr_o(addr),
        .wr_strobe_o(wr_strobe), .wr_data_o(wr_data),
        .rd_strobe_o(rd_strobe), .rd_data_i(rd_data));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t ns: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_expander_host_model.set_addr(a);
        i_expander_host_model.put_byte(d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        i_expander_host_model.set_addr(a);
        i_expander_host_model.get_byte(r);
        check(r, exp);
    endtask

    // Pins pass two sync flops and a flag stage, so five cycles settle.
    task automatic set_pins(input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk_i);
        pins_a <= a;
        pins_b <= b;
        repeat (5) @(posedge ref_clk_i);
    endtask

    task automatic lines(input logic [1:0] exp);
        for (int i = 0; i < 12 && {line_a, line_b} !== exp; i++)
            @(posedge ref_clk_i) #1;
        check({6'h0, line_a, line_b}, {6'h0, exp});
        if ({line_a, line_b} !== exp)
            finish_test();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check(dir_a & dir_b, 8'hFF);
        wr(8'h01, 8'h7F);
        check(dir_b, 8'h7F);
        wr(8'h01, 8'hFF);
        check({6'h0, line_a_oe, line_b_oe}, 8'h03);
        lines(2'b11);
        for (int k = 6; k < 16; k++)
            rd(8'(k), 8'h00);
        wr(8'h0A, 8'h18);
        rd(8'h0A, 8'h00);
        wr(8'h0C, 8'hA5);
        check(pu_a, 8'hA5);
        wr(8'h0D, 8'h5A);
        check(pu_b, 8'h5A);
        wr(8'h0E, 8'hFF);
        rd(8'h0E, 8'h00);
    endtask

    task automatic t_default();
        wr(8'h04, 8'h01);
        wr(8'h08, 8'h01);
        set_pins(8'h02, 8'h00);
        lines(2'b11);
        set_pins(8'h03, 8'h00);
        lines(2'b01);
        rd(8'h0E, 8'h01);
        wr(8'h0E, 8'hFE);
        rd(8'h0E, 8'h01);
        rd(8'h10, 8'h03);
        rd(8'h12, 8'h03);
        lines(2'b01);
        set_pins(8'h07, 8'h00);
        rd(8'h10, 8'h03);
        set_pins(8'h00, 8'h00);
        lines(2'b01);
        rd(8'h12, 8'h00);
        lines(2'b11);
        wr(8'h00, 8'hFE);
        set_pins(8'h01, 8'h00);
        lines(2'b11);
        check(pu_a, 8'hA5);
        set_pins(8'h00, 8'h00);
        wr(8'h00, 8'hFF);
        wr(8'h02, 8'h0F);
        set_pins(8'hF0, 8'h3C);
        rd(8'h12, 8'hFF);
        rd(8'h13, 8'h3C);
        wr(8'h02, 8'h00);
        set_pins(8'h00, 8'h00);
    endtask

    task automatic t_prev();
        wr(8'h08, 8'h00);
        wr(8'h0A, 8'h01);
        set_pins(8'h01, 8'h00);
        lines(2'b01);
        rd(8'h12, 8'h01);
        lines(2'b01);
        rd(8'h10, 8'h01);
        lines(2'b11);
        set_pins(8'h00, 8'h00);
        lines(2'b01);
        rd(8'h10, 8'h00);
        lines(2'b11);
        wr(8'h04, 8'h00);
        wr(8'h0A, 8'h00);
    endtask

    task automatic t_lines();
        wr(8'h05, 8'h80);
        wr(8'h09, 8'h80);
        set_pins(8'h00, 8'h80);
        lines(2'b10);
        wr(8'h0A, 8'h40);
        lines(2'b00);
        wr(8'h0A, 8'h02);
        lines(2'b01);
        check({6'h0, line_a_oe, line_b_oe}, 8'h03);
        wr(8'h0A, 8'h06);
        lines(2'b00);
        check({6'h0, line_a_oe, line_b_oe}, 8'h01);
        set_pins(8'h00, 8'h00);
        rd(8'h13, 8'h00);
        check({6'h0, line_a_oe, line_b_oe}, 8'h00);
        wr(8'h0A, 8'h00);
        lines(2'b11);
        wr(8'h05, 8'h00);
    endtask

    task automatic t_pointer();
        i_expander_host_model.set_addr(8'h14);
        i_expander_host_model.put_byte(8'hAA);
        i_expander_host_model.put_byte(8'h55);
        check(latch_a, 8'hAA);
        check(latch_b, 8'h55);
        rd(8'h15, 8'h55);
        wr(8'h0A, 8'h20);
        i_expander_host_model.set_addr(8'h14);
        i_expander_host_model.put_byte(8'h11);
        i_expander_host_model.put_byte(8'h22);
        check(latch_a, 8'h22);
        check(latch_b, 8'h55);
        wr(8'h0A, 8'h00);
        wr(8'h12, 8'h3C);
        check(latch_a, 8'h3C);
    endtask

    task automatic t_bank();
        i_expander_host_model.set_addr(8'h0A);
        i_expander_host_model.put_byte(8'h80);
        i_expander_host_model.get_byte(v);
        check(v, 8'h00);
        rd(8'h1A, 8'h55);
        rd(8'h06, 8'hA5);
        rd(8'h16, 8'h5A);
        wr(8'h05, 8'h00);
        rd(8'h0D, 8'h5A);
    endtask

    initial
    begin
        rst_i = 1'b1;
        pins_a = 8'h00;
        pins_b = 8'h00;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_default();
        t_prev();
        t_lines();
        t_pointer();
        t_bank();
        finish_test();
    end
endmodule

`default_nettype wire
